// [common/nfb_pkg.sv]
// Purpose: constants for the nor flash bus operation decode block
// Assumes: 16-bit data bus, host pins sampled by the 125 MHz clock
// Notes: identity-free; widths are defaults only
package nfb_pkg;
    localparam int NFB_DATA_W = 16;
    localparam int NFB_ADDR_W = 26;
    localparam int NFB_BLOCK_W = 10;
    localparam int NFB_CFG_W = 16;
    localparam int NFB_WAIT_POL_BIT = 10;
    localparam logic [15:0] NFB_CFG_RESET = 16'h0400;
    localparam int NFB_LAT_CYC = 3;
    typedef enum logic [4:0] {
        NFB_ST_RESET = 5'h01,
        NFB_ST_STANDBY = 5'h02,
        NFB_ST_OUTDIS = 5'h04,
        NFB_ST_READ = 5'h08,
        NFB_ST_WRITE = 5'h10
    } nfb_op_t;
endpackage

// [hdl/nfb_bus_decode.sv]
// Purpose: bus operation decode, latching and output enables of a parallel nor flash
// Assumes: all pins sampled through two flip-flops on clock_in; host clock is a sampled input
// Notes: array contents come from the core via rd_data_in; writes leave on wr_strobe_out
`timescale 1ns/1ps
// Function
// [RL1] cfg bit 10 sets wait polarity
// [RL2] wait driven only when select and oe low
// [RL3] sync read: wait asserted until data valid
// [RL4] async and write: wait deasserted when driven
// [RL5] upper address bits select accessed block
// [RL6] addr_valid_n low opens address latches
// [RL7] oe low on read drives data
// [RL8] host read: reset, we high, ce oe low
// [RL9] host write: ce we low, oe high
// [RL10] capture write on first rising strobe
// [RL11] oe high floats data and wait
// [RL12] ce high: standby, outputs floated
// [RL13] reset low: clear automation, ignore writes, float
// [RL14] reset exit: async read array mode
// [RL15] sync: latch on adv rise or clock edge
// [RL16] async: latch on adv rise, else flow
// [RL17] host releases data before asserting oe
module nfb_bus_decode
    import nfb_pkg::*;
#(
    parameter int DATA_W = NFB_DATA_W,
    parameter int ADDR_W = NFB_ADDR_W,
    parameter int BLOCK_W = NFB_BLOCK_W,
    parameter int LAT_CYC = NFB_LAT_CYC
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // flash control pins
    input wire logic dev_rst_n_in,
    input wire logic chip_sel_n_in,
    input wire logic out_en_n_in,
    input wire logic wr_en_n_in,
    input wire logic addr_valid_n_in,
    input wire logic host_clk_in,
    input wire logic [ADDR_W-1:0] addr_in,
    // data bus
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_out,
    // wait pin
    output logic wait_out,
    output logic wait_oe_out,
    // core side
    input wire logic [DATA_W-1:0] rd_data_in,
    input wire logic [NFB_CFG_W-1:0] read_config_reg_in,
    input wire logic sync_mode_in,
    output logic [ADDR_W-1:0] addr_out,
    output logic [BLOCK_W-1:0] block_out,
    output logic wr_strobe_out,
    output logic [ADDR_W-1:0] wr_addr_out,
    output logic [DATA_W-1:0] wr_data_out,
    output logic sync_mode_out,
    output logic [4:0] op_out
);
    logic [5:0] ctl_s1_r, ctl_s2_r, ctl_d_r;
    logic [ADDR_W-1:0] addr_s1_r, addr_s2_r;
    logic [DATA_W-1:0] dq_s1_r, dq_s2_r;
    logic [ADDR_W-1:0] addr_lat_r, addr_lat_nxt;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [DATA_W-1:0] wr_data_r;
    logic wr_strobe_r, sync_r, addr_held_r;
    logic [3:0] lat_cnt_r, lat_cnt_nxt;
    logic [DATA_W-1:0] dq_r;
    logic dq_oe_r, wait_r, wait_oe_r;
    nfb_op_t op_r, op_nxt;

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctl_s1_r <= 6'h3F;
            ctl_s2_r <= 6'h3F;
            ctl_d_r <= 6'h3F;
            addr_s1_r <= '0;
            addr_s2_r <= '0;
            dq_s1_r <= '0;
            dq_s2_r <= '0;
        end else begin
            ctl_s1_r <= {host_clk_in, addr_valid_n_in, wr_en_n_in, out_en_n_in, chip_sel_n_in, dev_rst_n_in};
            ctl_s2_r <= ctl_s1_r;
            ctl_d_r <= ctl_s2_r;
            addr_s1_r <= addr_in;
            addr_s2_r <= addr_s1_r;
            dq_s1_r <= dq_in;
            dq_s2_r <= dq_s1_r;
        end
    end

    wire rst_n = ctl_s2_r[0];
    wire ce_n = ctl_s2_r[1];
    wire oe_n = ctl_s2_r[2];
    wire we_n = ctl_s2_r[3];
    wire adv_n = ctl_s2_r[4];
    wire hclk = ctl_s2_r[5];
    wire ce_rise = ce_n & ~ctl_d_r[1];
    wire we_rise = we_n & ~ctl_d_r[3];
    wire adv_rise = adv_n & ~ctl_d_r[4];
    wire hclk_rise = hclk & ~ctl_d_r[5];
    wire ce_was = ~ctl_d_r[1];
    wire we_was = ~ctl_d_r[3];
    wire wpol = read_config_reg_in[NFB_WAIT_POL_BIT]; // RL1
    wire drive_ok = rst_n & ~ce_n & ~oe_n; // RL2 RL11 RL12 RL13
    wire rd_op = drive_ok & we_n; // RL8
    wire wr_cap = rst_n & ce_was & we_was & (ce_rise | we_rise) & ctl_d_r[2]; // RL9 RL10 RL13
    wire sync_latch = sync_r & ~adv_n & hclk_rise & ~addr_held_r; // RL15
    wire data_ok = ~sync_r | (lat_cnt_r == 4'h0);

    // address latch: open while adv low (in sync mode only until the first host clock rise), held from its rise
    always_comb begin
        addr_lat_nxt = addr_lat_r;
        if (!adv_n && !(sync_r && addr_held_r))
            addr_lat_nxt = addr_s2_r; // RL6 RL16
        if (sync_latch)
            addr_lat_nxt = addr_s2_r; // RL15
    end

    always_comb begin
        if (!rst_n)
            op_nxt = NFB_ST_RESET;
        else if (ce_n)
            op_nxt = NFB_ST_STANDBY;
        else if (!oe_n)
            op_nxt = NFB_ST_READ;
        else if (!we_n)
            op_nxt = NFB_ST_WRITE;
        else
            op_nxt = NFB_ST_OUTDIS;
    end

    always_comb begin
        lat_cnt_nxt = lat_cnt_r;
        if (!rd_op || (sync_r && !adv_n && !addr_held_r))
            lat_cnt_nxt = 4'(LAT_CYC);
        else if (sync_r && hclk_rise && lat_cnt_r != 4'h0)
            lat_cnt_nxt = lat_cnt_r - 4'h1;
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            op_r <= NFB_ST_RESET;
            addr_lat_r <= '0;
            addr_held_r <= 1'b0;
            sync_r <= 1'b0;
            lat_cnt_r <= 4'h0;
        end else begin
            op_r <= op_nxt;
            addr_lat_r <= addr_lat_nxt;
            lat_cnt_r <= lat_cnt_nxt;
            if (adv_n)
                addr_held_r <= 1'b0;
            else if (sync_latch)
                addr_held_r <= 1'b1;
            if (!rst_n)
                sync_r <= 1'b0; // RL14
            else
                sync_r <= sync_mode_in;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_strobe_r <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= '0;
        end else begin
            wr_strobe_r <= wr_cap; // RL10
            if (wr_cap) begin
                wr_addr_r <= addr_lat_r;
                wr_data_r <= dq_s2_r;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dq_r <= '0;
            dq_oe_r <= 1'b0;
            wait_r <= 1'b0;
            wait_oe_r <= 1'b0;
        end else begin
            dq_oe_r <= rd_op; // RL7 RL11 RL12 RL13
            dq_r <= rd_data_in;
            wait_oe_r <= drive_ok; // RL2
            wait_r <= (rd_op && !data_ok) ? wpol : ~wpol; // RL3 RL4
        end
    end

    assign dq_out = dq_r;
    assign dq_oe_out = dq_oe_r;
    assign wait_out = wait_r;
    assign wait_oe_out = wait_oe_r;
    assign addr_out = addr_lat_r;
    assign block_out = addr_lat_r[ADDR_W-1 -: BLOCK_W]; // RL5
    assign wr_strobe_out = wr_strobe_r;
    assign wr_addr_out = wr_addr_r;
    assign wr_data_out = wr_data_r;
    assign sync_mode_out = sync_r;
    assign op_out = op_r;

    // steps of a write capture
    sequence s_wr_armed_edge;
        rst_n && ce_was && we_was && ctl_d_r[2] && (ce_rise || we_rise);
    endsequence

    sequence s_wr_pulse;
        wr_strobe_out ##1 !wr_strobe_out;
    endsequence

    // steps of a sync address latch
    sequence s_sync_first_edge;
        sync_r && !adv_n && !addr_held_r && hclk_rise;
    endsequence

    sequence s_sync_held;
        sync_r && addr_held_r && !adv_n;
    endsequence

    // output enables and read data
    a_wait_float: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL2
        !drive_ok |=> !wait_oe_out)
        else $error("wait driven while deselected");

    a_wait_drive: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL2
        drive_ok |=> wait_oe_out)
        else $error("wait not driven while selected");

    a_dq_float: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL11
        (oe_n || ce_n) |=> !dq_oe_out)
        else $error("data driven with oe or ce high");

    a_outdis_float: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL11
        (rst_n && !ce_n && oe_n) |=> (!dq_oe_out && !wait_oe_out))
        else $error("outputs driven with oe high");

    a_standby_float: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL12
        (rst_n && ce_n) |=> (!dq_oe_out && !wait_oe_out && op_out == NFB_ST_STANDBY))
        else $error("standby not floating");

    a_dq_drive: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL7
        rd_op |=> dq_oe_out)
        else $error("read not driving data");

    a_rd_data: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL7
        rd_op |=> dq_out == $past(rd_data_in))
        else $error("read data not passed");

    // pin reset
    a_reset_quiet: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL13
        !rst_n |=> (!dq_oe_out && !wait_oe_out && !wr_strobe_out && !sync_mode_out))
        else $error("reset not quiet");

    a_op_reset: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL13
        !rst_n |=> op_out == NFB_ST_RESET)
        else $error("reset op not shown");

    a_reset_exit: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL14
        $rose(rst_n) |-> !sync_mode_out)
        else $error("reset exit not async");

    // wait level
    a_async_wait: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL4
        (drive_ok && !sync_r) |=> wait_out == !$past(wpol))
        else $error("wait asserted in async mode");

    a_wait_pol: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL1
        (rd_op && !data_ok) |=> wait_out == $past(wpol))
        else $error("wait level not from polarity bit");

    a_sync_wait: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL3
        (rd_op && sync_r && lat_cnt_r != 4'h0) |=> wait_out == $past(wpol))
        else $error("wait missing on invalid data");

    a_sync_release: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL3
        (rd_op && sync_r && lat_cnt_r == 4'h0) |=> wait_out == !$past(wpol))
        else $error("wait held on valid data");

    // write capture
    a_wr_capture: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL10
        wr_cap |=> (wr_strobe_out && wr_data_out == $past(dq_s2_r)))
        else $error("write not captured");

    a_wr_once: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL10
        s_wr_armed_edge |=> s_wr_pulse)
        else $error("write strobe not single");

    a_wr_addr: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL10
        s_wr_armed_edge |=> wr_addr_out == $past(addr_lat_r))
        else $error("write address not captured");

    // address latch
    a_addr_flow: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL16
        (!adv_n && !sync_r && !$past(sync_r)) |=> addr_out == $past(addr_s2_r))
        else $error("latch not transparent");

    a_addr_hold: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL15
        (adv_n && $past(adv_n)) |=> $stable(addr_out))
        else $error("address moved while held");

    a_sync_capture: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL15
        s_sync_first_edge |=> addr_out == $past(addr_s2_r))
        else $error("sync address not latched");

    a_sync_keep: assert property (@(posedge clock_in) disable iff (!rstn_in) // RL15
        s_sync_held |=> $stable(addr_out))
        else $error("sync address moved after latch");
endmodule // nfb_bus_decode

// [testbench/nfb_host_model.sv]
// Purpose: host controller model facing the bus decode
// Assumes: bench says when to clock and drive
// Notes: a released bus toggles each cycle
`timescale 1ns/1ps
module nfb_host_model (
    // bench control
    input wire logic clock_in,
    input wire logic clk_run_in,
    input wire logic drive_in,
    input wire logic [15:0] data_in,
    // host pins
    output logic host_clk_out,
    output logic [15:0] dq_out = 16'h0
);
    initial begin
        host_clk_out = 1'h0;
        #3;
        forever begin
            #40;
            host_clk_out = clk_run_in & ~host_clk_out;
        end
    end
    always @(posedge clock_in) begin
        dq_out <= drive_in ? data_in : ~dq_out;
    end
endmodule // nfb_host_model

// [testbench/tb_nfb_bus_decode.sv]
// Purpose: bench for the bus decode
// Assumes: pins change at rising edges
// Notes: partner makes host clock and data
`timescale 1ns/1ps
module tb_nfb_bus_decode;
    import nfb_pkg::*;
    logic clock_in = 0, rstn_in = 0, rst_n = 0, ce_n = 1, oe_n = 1, we_n = 1, adv_n = 1;
    logic sm = 0, run = 0, drv = 0, hclk, wstb, pol, dqoe, woe, wt, smo, seen;
    logic [25:0] addr = 0, aout, wa, a0;
    logic [15:0] rd = 0, wd = 0, dq, dqo, wdo, cfg = NFB_CFG_RESET;
    logic [9:0] blk;
    logic [4:0] op;
    int fail_count = 0, n_checks = 0, seed = 32'h7ee4, i;
    always #4 clock_in = ~clock_in;
    nfb_host_model i_nfb_host_model (.clock_in(clock_in), .clk_run_in(run), .drive_in(drv),
        .data_in(wd), .host_clk_out(hclk), .dq_out(dq));
    nfb_bus_decode i_nfb_bus_decode (.clock_in(clock_in), .rstn_in(rstn_in), .dev_rst_n_in(rst_n),
        .chip_sel_n_in(ce_n), .out_en_n_in(oe_n), .wr_en_n_in(we_n), .addr_valid_n_in(adv_n),
        .host_clk_in(hclk), .addr_in(addr), .dq_in(dq), .dq_out(dqo), .dq_oe_out(dqoe),
        .wait_out(wt), .wait_oe_out(woe), .rd_data_in(rd), .read_config_reg_in(cfg),
        .sync_mode_in(sm), .addr_out(aout), .block_out(blk), .wr_strobe_out(wstb),
        .wr_addr_out(wa), .wr_data_out(wdo), .sync_mode_out(smo), .op_out(op));
    task automatic conclude;
        $display("counts: %0d checks, %0d mismatches", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    // order: reset, select, output enable, write enable
    task automatic pins(input logic [3:0] p);
        @(posedge clock_in);
        {rst_n, ce_n, oe_n, we_n} <= p;
        cyc(5);
    endtask
    task automatic strobe;
        seen = 1'h0;
        repeat (12) begin
            @(posedge clock_in);
            if (wstb === 1'h1) seen = 1'h1;
        end
    endtask
    initial begin
        #200000;
        chk(0, 1, "run timed out");
        conclude;
    end
    initial begin
        cyc(20);
        rstn_in <= 1;
        rst_n <= 1;
        adv_n <= 0;
        pins(4'hF);
        chk({dqoe, woe, op}, {2'h0, 5'h02}, "standby");
        for (i = 0; i < 8; i++) begin
            pol = i[0];
            cfg[10] <= pol;
            addr <= 26'($random(seed));
            rd <= 16'($random(seed));
            pins(4'h9);
            chk({dqoe, woe, wt, op, dqo}, {2'h3, ~pol, 5'h08, rd}, "read outputs");
            chk({aout, blk}, {addr, addr[25:16]}, "address path");
            a0 = addr;
            adv_n <= 1;
            cyc(4);
            addr <= ~a0;
            cyc(5);
            chk(aout, a0, "async latch");
            adv_n <= 0;
            pins(4'hB);
            chk({dqoe, woe, op}, {2'h0, 5'h04}, "output disable");
            wd <= 16'($random(seed));
            drv <= 1;
            pins(4'hA);
            chk({woe, op}, {1'h0, 5'h10}, "write decode");
            {ce_n, we_n} <= i[1] ? 2'h2 : 2'h1;
            strobe;
            chk({seen, wa, wdo}, {1'h1, addr, wd}, "write capture");
            drv <= 0;
            pins(4'hF);
        end
        pins(4'h2);
        chk({dqoe, woe, op, smo}, {2'h0, 5'h01, 1'h0}, "pin reset");
        we_n <= 1;
        strobe;
        chk(seen, 0, "write in reset");
        pins(4'h9);
        chk({op, woe, wt}, {5'h08, 1'h1, ~pol}, "async after reset");
        sm <= 1;
        run <= 1;
        adv_n <= 1;
        pins(4'hF);
        adv_n <= 0;
        a0 = addr;
        pins(4'h9);
        chk({woe, wt}, {1'h1, pol}, "sync wait asserted");
        i = 0;
        while (wt !== ~pol && i < 80) begin
            cyc(1);
            i++;
        end
        chk({wt, dqo}, {~pol, rd}, "sync wait released");
        addr <= ~a0;
        cyc(5);
        chk(aout, a0, "sync latch");
        conclude;
    end
endmodule // tb_nfb_bus_decode
